// [hdl/pcgb_top.sv]
// Peripheral clock gate bank: one disable register and clock enables for 13 peripherals.
// Assumes an Avalon-MM master on core_clk_in and peripherals that honour the enables.
//
// What the document requires
// R01: Bits 15..12 stop timers five to two.
// R02: Bit 11 stops timer one.
// R03: A zero bit keeps its peripheral clocked.
// R04: Bit 8 stops the codec serial interface.
// R05: Bits 7..3, 1, 0 stop serial, CAN, ADC.
// R06: Gate follows a bit change one instruction later; the enable outputs here follow three clocks (12 ns) later.
// R07: Disabled peripheral ignores writes, reads undefined.
// R08: Bits 10, 9, 2 read zero; reset zero.
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`include "pcgb_defines.svh"

module pcgb_top
  import pcgb_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Avalon-MM slave.
  input wire logic [`PCGB_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [`PCGB_DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [`PCGB_DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Clock enables, high while the peripheral is clocked.
  output logic timer5_clk_en_out,
  output logic timer4_clk_en_out,
  output logic timer3_clk_en_out,
  output logic timer2_clk_en_out,
  output logic timer1_clk_en_out,
  output logic codec_if_clk_en_out,
  output logic i2c_ctrl_clk_en_out,
  output logic uart2_clk_en_out,
  output logic uart1_clk_en_out,
  output logic spi_ctrl2_clk_en_out,
  output logic spi_ctrl1_clk_en_out,
  output logic can_ctrl_clk_en_out,
  output logic adc_clk_en_out,
  // Register access permits, low while a peripheral is disabled.
  output logic [`PCGB_REG_W-1:0] periph_access_ok_out
);
  localparam int NP = `PCGB_NUM_PERIPH;
  localparam int BIT_IDX [NP] = '{`PCGB_BIT_TIMER5, `PCGB_BIT_TIMER4, `PCGB_BIT_TIMER3,
    `PCGB_BIT_TIMER2, `PCGB_BIT_TIMER1, `PCGB_BIT_CODEC, `PCGB_BIT_I2C, `PCGB_BIT_UART2,
    `PCGB_BIT_UART1, `PCGB_BIT_SPI2, `PCGB_BIT_SPI1, `PCGB_BIT_CAN, `PCGB_BIT_ADC};

  pcgb_reg_t peripheral_disable_one_r;
  pcgb_reg_t peripheral_disable_one_nxt;
  pcgb_bus_e bus_state_r;
  pcgb_bus_e bus_state_nxt;
  logic waitrequest_r;
  logic waitrequest_nxt;
  pcgb_data_t readdata_r;
  pcgb_data_t readdata_nxt;
  pcgb_reg_t gate_en_r;
  pcgb_reg_t gate_en_nxt;
  pcgb_reg_t settled_r;
  pcgb_reg_t settled_nxt;
  pcgb_reg_t gate_en_w;
  pcgb_reg_t settled_w;
  pcgb_reg_t wmask;
  logic req;

  assign req = avs_read_in | avs_write_in;
  assign wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}} & `PCGB_WRITE_MASK;

  // Every access takes one wait cycle; the answer stands at the second edge.
  always_comb begin
    bus_state_nxt = PCGB_IDLE;
    peripheral_disable_one_nxt = peripheral_disable_one_r;
    readdata_nxt = readdata_r;
    unique case (bus_state_r)
      PCGB_IDLE: begin
        if (req) begin
          bus_state_nxt = PCGB_ACK;
          readdata_nxt = `PCGB_UNMAPPED_READ;
          if (avs_address_in == `PCGB_OFS_DISABLE_ONE) begin
            readdata_nxt = {16'h0000, peripheral_disable_one_r};
            if (avs_write_in) begin
              // Unimplemented bits stay zero whatever is written. [R08]
              peripheral_disable_one_nxt = (peripheral_disable_one_r & ~wmask)
                | (avs_writedata_in[15:0] & wmask); // [R01] [R02] [R04] [R05]
            end
          end else if (avs_address_in == `PCGB_OFS_STATUS) begin
            readdata_nxt = {settled_r, gate_en_r};
          end
        end
      end
      PCGB_ACK: begin
        bus_state_nxt = PCGB_IDLE;
      end
    endcase
    // Registered so that the answer leaves straight from a flip-flop.
    waitrequest_nxt = (bus_state_nxt != PCGB_ACK);
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      peripheral_disable_one_r <= `PCGB_RESET_VALUE; // [R08]
      bus_state_r <= PCGB_IDLE;
      waitrequest_r <= 1'b1;
      readdata_r <= '0;
    end else begin
      peripheral_disable_one_r <= peripheral_disable_one_nxt;
      bus_state_r <= bus_state_nxt;
      waitrequest_r <= waitrequest_nxt;
      readdata_r <= readdata_nxt;
    end
  end

  assign avs_waitrequest_out = waitrequest_r;
  assign avs_readdata_out = readdata_r;

  // Unimplemented positions keep a running enable and a settled flag.
  generate
    for (genvar g = 0; g < `PCGB_REG_W; g++) begin : g_unused
      if (g == 10 || g == 9 || g == 2) begin : g_tie
        assign gate_en_w[g] = 1'b1;
        assign settled_w[g] = 1'b1;
      end
    end
    for (genvar i = 0; i < NP; i++) begin : g_gate
      pcgb_gate_delay u_dly (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .disable_in(peripheral_disable_one_r[BIT_IDX[i]]),
        .clk_en_out(gate_en_w[BIT_IDX[i]]), // [R06]
        .settled_out(settled_w[BIT_IDX[i]])
      );
    end
  endgenerate

  // One more register keeps every output straight from a flip-flop.
  always_comb begin
    gate_en_nxt = gate_en_w;
    settled_nxt = settled_w;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gate_en_r <= '1; // [R03]
      settled_r <= '1;
    end else begin
      gate_en_r <= gate_en_nxt;
      settled_r <= settled_nxt;
    end
  end

  // The peripherals block their own register writes while this is low. [R07]
  assign periph_access_ok_out = gate_en_r;
  assign timer5_clk_en_out = gate_en_r[`PCGB_BIT_TIMER5]; // [R01]
  assign timer4_clk_en_out = gate_en_r[`PCGB_BIT_TIMER4];
  assign timer3_clk_en_out = gate_en_r[`PCGB_BIT_TIMER3];
  assign timer2_clk_en_out = gate_en_r[`PCGB_BIT_TIMER2];
  assign timer1_clk_en_out = gate_en_r[`PCGB_BIT_TIMER1]; // [R02]
  assign codec_if_clk_en_out = gate_en_r[`PCGB_BIT_CODEC]; // [R04]
  assign i2c_ctrl_clk_en_out = gate_en_r[`PCGB_BIT_I2C]; // [R05]
  assign uart2_clk_en_out = gate_en_r[`PCGB_BIT_UART2];
  assign uart1_clk_en_out = gate_en_r[`PCGB_BIT_UART1];
  assign spi_ctrl2_clk_en_out = gate_en_r[`PCGB_BIT_SPI2];
  assign spi_ctrl1_clk_en_out = gate_en_r[`PCGB_BIT_SPI1];
  assign can_ctrl_clk_en_out = gate_en_r[`PCGB_BIT_CAN];
  assign adc_clk_en_out = gate_en_r[`PCGB_BIT_ADC];
endmodule

// [hdl/pcgb_defines.svh]
// Offsets, field positions, reset values and timing counts of the peripheral clock gate bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PCGB_DEFINES_SVH
`define PCGB_DEFINES_SVH

`define PCGB_ADDR_W 4
`define PCGB_DATA_W 32
`define PCGB_REG_W 16
`define PCGB_OFS_DISABLE_ONE 4'h0
`define PCGB_OFS_STATUS 4'h4
`define PCGB_RESET_VALUE 16'h0000
`define PCGB_WRITE_MASK 16'hF9FB
`define PCGB_NUM_PERIPH 13
`define PCGB_BIT_TIMER5 15
`define PCGB_BIT_TIMER4 14
`define PCGB_BIT_TIMER3 13
`define PCGB_BIT_TIMER2 12
`define PCGB_BIT_TIMER1 11
`define PCGB_BIT_CODEC 8
`define PCGB_BIT_I2C 7
`define PCGB_BIT_UART2 6
`define PCGB_BIT_UART1 5
`define PCGB_BIT_SPI2 4
`define PCGB_BIT_SPI1 3
`define PCGB_BIT_CAN 1
`define PCGB_BIT_ADC 0
`define PCGB_INSTR_CYCLE_NS 8
`define PCGB_CLK_PERIOD_NS 4
`define PCGB_DELAY_CYCLES ((`PCGB_INSTR_CYCLE_NS + `PCGB_CLK_PERIOD_NS - 1) / `PCGB_CLK_PERIOD_NS)
`define PCGB_UNMAPPED_READ 32'h0000_0000

`endif

// [hdl/pcgb_pkg.sv]
// Types of the peripheral clock gate bank.
// Assumes pcgb_defines.svh is on the include path.
`include "pcgb_defines.svh"

package pcgb_pkg;
  typedef logic [`PCGB_REG_W-1:0] pcgb_reg_t;
  typedef logic [`PCGB_ADDR_W-1:0] pcgb_addr_t;
  typedef logic [`PCGB_DATA_W-1:0] pcgb_data_t;
  typedef enum logic [1:0] {
    PCGB_IDLE = 2'h0,
    PCGB_ACK = 2'h1
  } pcgb_bus_e;
endpackage

// [hdl/pcgb_gate_delay.sv]
// One gate enable with a fixed settle delay from its disable bit.
// Assumes the disable bit comes from a register on the same clock.
`include "pcgb_defines.svh"

module pcgb_gate_delay
  import pcgb_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Disable bit and resulting gate state.
  input wire logic disable_in,
  output logic clk_en_out,
  output logic settled_out
);
  localparam int DLY = `PCGB_DELAY_CYCLES;

  logic [DLY-1:0] pipe_r;
  logic [DLY-1:0] pipe_nxt;

  // The bit travels DLY stages before the gate sees it, for set and clear alike.
  always_comb begin
    if (DLY > 1) begin
      pipe_nxt = {pipe_r[DLY-2:0], disable_in}; // [R06]
    end else begin
      pipe_nxt = {DLY{disable_in}};
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pipe_r <= '0;
    end else begin
      pipe_r <= pipe_nxt;
    end
  end

  // A zero in the last stage keeps the clock running.
  assign clk_en_out = ~pipe_r[DLY-1]; // [R03]
  assign settled_out = (pipe_r == {DLY{disable_in}});
endmodule

// [verif/pcgb_sva.sv]
// Checker of the gate bank's bus answer and clock enable ports.
// Assumes binding into pcgb_top, with one master that keeps the bus rules.
`include "pcgb_defines.svh"
module pcgb_sva (
  // Clock, reset and bus.
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [`PCGB_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [`PCGB_DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [`PCGB_DATA_W-1:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Enables.
  input wire logic timer5_clk_en_out,
  input wire logic timer1_clk_en_out,
  input wire logic codec_if_clk_en_out,
  input wire logic adc_clk_en_out,
  input wire logic [`PCGB_REG_W-1:0] periph_access_ok_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire logic take = (avs_read_in || avs_write_in) && avs_waitrequest_out;
  wire logic wr0 = take && avs_write_in && avs_address_in == 4'h0 && avs_byteenable_in == 4'hF;
  wire logic rd_ans = avs_read_in && !avs_waitrequest_out;
  ans_next_a: assert property (take |=> !avs_waitrequest_out)
    else $error("bus answer late");
  wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer held too long");
  // Four cycles covers the register write, the two-clock settle and the output register.
  t5_delay_a: assert property (wr0 |-> ##4 timer5_clk_en_out == !$past(avs_writedata_in[15], 4))
    else $error("timer5 enable wrong after write");
  adc_delay_a: assert property (wr0 |-> ##4 adc_clk_en_out == !$past(avs_writedata_in[0], 4))
    else $error("adc enable wrong after write");
  t1_map_a: assert property (timer1_clk_en_out == periph_access_ok_out[11])
    else $error("timer1 enable and permit differ");
  enable_map_a: assert property (codec_if_clk_en_out == periph_access_ok_out[8] && timer5_clk_en_out == periph_access_ok_out[15] && adc_clk_en_out == periph_access_ok_out[0])
    else $error("enable and permit differ");
  unimpl_zero_a: assert property (rd_ans && avs_address_in == 4'h0 |-> (avs_readdata_out & 32'hFFFF_0604) == 32'h0)
    else $error("unimplemented bits read one");
  ok_fixed_a: assert property (periph_access_ok_out[10] && periph_access_ok_out[9] && periph_access_ok_out[2])
    else $error("unused permit bits low");
  rst_clear_a: assert property ($rose(arst_n_in) |-> &periph_access_ok_out && avs_readdata_out == 32'h0)
    else $error("state not cleared by reset");
  unmap_zero_a: assert property (rd_ans && avs_address_in != 4'h0 && avs_address_in != 4'h4 |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  cover property (wr0);
  cover property (take && avs_read_in && avs_address_in == 4'h4);
  cover property ($rose(arst_n_in));
endmodule

// [verif/tb_pcgb_top.sv]
// Self-checking bench of the gate bank against a register model.
// Assumes the design and the checker are compiled before this file.
`include "pcgb_defines.svh"
module tb_pcgb_top
  import pcgb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  pcgb_addr_t avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  pcgb_data_t avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  pcgb_data_t avs_readdata_out;
  logic avs_waitrequest_out;
  logic timer5_clk_en_out, timer4_clk_en_out, timer3_clk_en_out, timer2_clk_en_out;
  logic timer1_clk_en_out, codec_if_clk_en_out, i2c_ctrl_clk_en_out, uart2_clk_en_out;
  logic uart1_clk_en_out, spi_ctrl2_clk_en_out, spi_ctrl1_clk_en_out, can_ctrl_clk_en_out;
  logic adc_clk_en_out;
  pcgb_reg_t periph_access_ok_out;
  pcgb_reg_t model_q;
  pcgb_data_t rd, d;
  logic [3:0] be;
  pcgb_addr_t addr_tab [5] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h4};
  int bad_count = 0;
  int check_count = 0;
  pcgb_top i_dut (.*);
  always #2 core_clk_in = ~core_clk_in;
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input pcgb_data_t exp, input pcgb_data_t got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Unused positions stay enabled, so the expectation sets them.
  task automatic chk_en(input pcgb_reg_t m);
    chk("enables", {16'h0, ~m | 16'h0604}, {16'h0, timer5_clk_en_out, timer4_clk_en_out,
      timer3_clk_en_out, timer2_clk_en_out, timer1_clk_en_out, 2'b11, codec_if_clk_en_out,
      i2c_ctrl_clk_en_out, uart2_clk_en_out, uart1_clk_en_out, spi_ctrl2_clk_en_out,
      spi_ctrl1_clk_en_out, 1'b1, can_ctrl_clk_en_out, adc_clk_en_out});
    chk("access ok", {16'h0, ~m | 16'h0604}, {16'h0, periph_access_ok_out});
  endtask
  // The trailing edge keeps a following request out of the release time step.
  task automatic bus(input logic wr, input pcgb_addr_t a, input pcgb_data_t wd, input logic [3:0] b);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_byteenable_in <= b;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge core_clk_in);
    while (avs_waitrequest_out !== 1'b0 && n < 20) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n == 20) bad_count++;
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  initial begin
    void'($urandom(32'h1C76B89A));
    repeat (8) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    @(posedge core_clk_in);
    model_q = 16'h0000;
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk("reset value", 32'h0, rd);
    chk_en(model_q);
    for (int i = 0; i < 30; i++) begin
      d = $urandom;
      be = i[0] ? 4'($urandom) : 4'hF;
      bus(1'b1, addr_tab[i % 5], d, be);
      if (addr_tab[i % 5] == 4'h0)
        model_q = (model_q & ~{{8{be[1]}}, {8{be[0]}}}) | (d[15:0] & {{8{be[1]}}, {8{be[0]}}} & 16'hF9FB);
      bus(1'b0, 4'h0, 32'h0, 4'hF);
      chk("register", {16'h0, model_q}, rd);
      repeat (6) @(posedge core_clk_in);
      chk_en(model_q);
    end
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    chk("status", {16'hF9FB, ~model_q & 16'hF9FB}, rd & 32'hF9FB_F9FB);
    bus(1'b0, 4'hC, 32'h0, 4'hF);
    chk("unmapped", 32'h0, rd);
    arst_n_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    @(posedge core_clk_in);
    chk_en(16'h0000);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk("second reset", 32'h0, rd);
    conclude();
  end
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
endmodule
bind pcgb_top pcgb_sva i_sva (.*);
